// ===== design/fdc_drive_regs_map.vh
// Register offsets, field positions, reset values and mode codes
// for the drive control and status register bank.
// Included by the decode and register design files of the bank, not by the edge_flag module; definitions only.
`ifndef FDC_DRIVE_REGS_MAP_VH
`define FDC_DRIVE_REGS_MAP_VH

// Register offsets from the controller base address
`define OFF_STATUS_SECOND  3'h1
`define OFF_OUTPUT_CONTROL 3'h2
`define OFF_TAPE_SCRATCH   3'h3
`define OFF_DIGITAL_INPUT  3'h7

// Host compatibility modes on mode_i
`define MODE_BASELINE      2'h0
`define MODE_ENHANCED      2'h1
`define MODE_LATCHED       2'h2

// Output control register fields
`define DOC_SEL_HI          1
`define DOC_SEL_LO          0
`define DOC_SOFT_RESET_N    2
`define DOC_DMA_IRQ_GATE    3
`define DOC_MOTOR_LO        4
`define DOC_MOTOR_HI        7

// Reset values and read enable patterns
`define DOC_RESET          8'h00
`define TAPE_RESET         2'h0
`define BUS_IDLE           8'h00
`define OE_OFF             8'hFF
`define OE_ALL_ON          8'h00
`define OE_TAPE_ONLY       8'hFC

// Enhanced layout constant top bits
`define ENH_TOP_BITS       2'h3

`endif

// ===== design/edge_flag.v
// One status bit driven by the rising edge of a sampled level.
// Assumes sig_i is synchronous to clk_i; in toggle mode the bit
// flips on each edge, otherwise it latches until clear_i.
`timescale 1ns/1ps

module edge_flag (
  input  wire clk_i,         // Controller clock
  input  wire reset_n_i,     // Hardware reset, active low
  input  wire sig_i,         // Level whose rising edge counts
  input  wire toggle_mode_i, // 1: toggle, 0: set and hold
  input  wire clear_i,       // Clears a held flag
  output reg  flag_o         // Status bit
);

  reg last;

  // Edge capture; a set in the clearing cycle wins so no event is lost
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Starts high so an input idling high shows no edge after reset
      last   <= 1'b1;
      flag_o <= 1'b0;
    end else begin
      last <= sig_i;
      if (sig_i && !last)
        flag_o <= toggle_mode_i ? ~flag_o : 1'b1;
      else if (clear_i && !toggle_mode_i)
        flag_o <= 1'b0;
    end
  end

endmodule

// ===== design/drive_decode.v
// Decodes the output control register into drive selects and
// motor enables, all active low. Pure combinational logic; the
// caller registers the results before they reach any pin.
`timescale 1ns/1ps
`include "fdc_drive_regs_map.vh"

module drive_decode (
  input  wire [7:0] doc_i,   // Output control register value
  input  wire       swap_i,  // 1: drives 0 and 1 exchanged
  output reg  [3:0] sel_n_o, // Drive selects, active low
  output reg  [3:0] mot_n_o  // Motor enables, active low
);

  wire [1:0] code;
  wire [3:0] mot;

  assign code = doc_i[`DOC_SEL_HI:`DOC_SEL_LO];
  assign mot  = doc_i[`DOC_MOTOR_HI:`DOC_MOTOR_LO];

  // binary code, at most one select, gated by its motor bit; normal, swapped decode
  always @* begin
    sel_n_o = 4'hF;
    case (code)
      2'h0: sel_n_o[swap_i ? 1 : 0] = ~mot[0];
      2'h1: sel_n_o[swap_i ? 0 : 1] = ~mot[1];
      2'h2: sel_n_o[2] = ~mot[2];
      default: sel_n_o[3] = ~mot[3];
    endcase
    // motor bits; swaps motors of drives 0 and 1
    mot_n_o[0] = swap_i ? ~mot[1] : ~mot[0];
    mot_n_o[1] = swap_i ? ~mot[0] : ~mot[1];
    mot_n_o[2] = ~mot[2];
    mot_n_o[3] = ~mot[3];
  end

endmodule

// ===== design/floppy_drive_control_status_regs.v
// Drive control and status registers of the floppy controller:
// second status register, output control register, tape scratch.
// Assumes a synchronous 8-bit host I/O strobe interface and drive
// and core signals already synchronous to clk_i.
`timescale 1ns/1ps
`include "fdc_drive_regs_map.vh"

module floppy_drive_control_status_regs #(
  parameter integer RESET_MIN_NS = 100, // Least soft reset width
  parameter integer CLK_MHZ      = 25   // Clock rate
) (
  input  wire       clk_i,                    // Controller clock
  input  wire       reset_n_i,                // Hard reset, active low
  input  wire [2:0] addr_i,                   // Register offset
  input  wire       rd_i,                     // Read strobe
  input  wire       wr_i,                     // Write strobe
  input  wire [7:0] data_i,                   // Write data
  output reg  [7:0] data_o,                   // Read data
  output reg  [7:0] data_oe_n_o,              // Per-bit enable, low drives
  input  wire [1:0] mode_i,                   // Compatibility mode
  input  wire       swap_drives_i,            // Swap drives 0 and 1
  input  wire       read_data_n_i,            // Read data from drive
  input  wire       write_data_n_i,           // Write data to drive
  input  wire       write_gate_out_i,         // Write gate to drive
  input  wire       second_drive_present_n_i, // Second drive fitted
  input  wire       dma_req_i,                // Core DMA request
  input  wire       irq_i,                    // Core interrupt
  input  wire       dma_ack_n_i,              // Host DMA acknowledge
  input  wire       tc_i,                     // Host terminal count
  output reg        dma_req_o,                // DMA request pin
  output reg        dma_req_oe_n_o,           // Its enable, low drives
  output reg        irq_o,                    // Interrupt pin
  output reg        irq_oe_n_o,               // Its enable, low drives
  output reg        dma_ack_n_o,              // Gated acknowledge to core
  output reg        tc_o,                     // Gated count to core
  output reg        soft_reset_o,             // Controller reset level
  output reg        drive_select_out_zero_n_o,  // Drive select 0
  output reg        drive_select_out_one_n_o,   // Drive select 1
  output reg        drive_select_out_two_n_o,   // Drive select 2
  output reg        drive_select_out_three_n_o, // Drive select 3
  output reg        motor_out_zero_n_o,       // Motor 0
  output reg        motor_out_one_n_o,        // Motor 1
  output reg        motor_out_two_n_o,        // Motor 2
  output reg        motor_out_three_n_o       // Motor 3
);

  // least reset width in cycles, rounded up; the host must
  // keep it, and even back-to-back writes span a full clock here
  localparam integer RESET_MIN_CYC =
    (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

  // Address match of a taken strobe
  function hit;
    input       strobe;
    input [2:0] addr;
    input [2:0] off;
    begin
      hit = strobe && (addr == off);
    end
  endfunction

  reg  [7:0] drive_output_control;
  reg  [1:0] tape_select_scratch;
  reg  [7:0] next_data;
  reg  [7:0] next_oe_n;
  wire [3:0] sel_n;
  wire [3:0] mot_n;
  wire       enhanced;
  wire       latched;
  wire       input_read;
  wire       gate;
  wire       rd_toggle;
  wire       wd_toggle;
  wire       wg_flag;
  wire       rd_flag;
  wire       wd_flag;
  wire [7:0] drive_status_second;

  // mode selection; code 3 is neither layout, so a status
  // read floats there and the gate bit alone opens the pins
  assign enhanced = (mode_i == `MODE_ENHANCED);
  assign latched  = (mode_i == `MODE_LATCHED);

  // Reading the digital input register clears latched status bits;
  // that register lives elsewhere, only its read strobe is seen here
  assign input_read = hit(rd_i, addr_i, `OFF_DIGITAL_INPUT);

  // output register write; soft reset bit leaves the rest
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      drive_output_control <= `DOC_RESET;
    else if (hit(wr_i, addr_i, `OFF_OUTPUT_CONTROL))
      drive_output_control <= data_i;
  end

  // tape scratch, hard reset only; two bits kept
  // The bits are only stored; nothing inside the bank uses them
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      tape_select_scratch <= `TAPE_RESET;
    else if (hit(wr_i, addr_i, `OFF_TAPE_SCRATCH))
      tape_select_scratch <= data_i[1:0];
  end

  // controller held in reset while the bit reads zero
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      soft_reset_o <= 1'b1;
    else
      soft_reset_o <= ~drive_output_control[`DOC_SOFT_RESET_N];
  end

  drive_decode u_decode (
    .doc_i   (drive_output_control),
    .swap_i  (swap_drives_i),
    .sel_n_o (sel_n),
    .mot_n_o (mot_n)
  );

  // Drive pins registered; hard reset deasserts all of them
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_select_out_zero_n_o  <= 1'b1;
      drive_select_out_one_n_o   <= 1'b1;
      drive_select_out_two_n_o   <= 1'b1;
      drive_select_out_three_n_o <= 1'b1;
      motor_out_zero_n_o         <= 1'b1;
      motor_out_one_n_o          <= 1'b1;
      motor_out_two_n_o          <= 1'b1;
      motor_out_three_n_o        <= 1'b1;
    end else begin
      drive_select_out_zero_n_o  <= sel_n[0];
      drive_select_out_one_n_o   <= sel_n[1];
      drive_select_out_two_n_o   <= sel_n[2];
      drive_select_out_three_n_o <= sel_n[3];
      motor_out_zero_n_o         <= mot_n[0];
      motor_out_one_n_o          <= mot_n[1];
      motor_out_two_n_o          <= mot_n[2];
      motor_out_three_n_o        <= mot_n[3];
    end
  end

  // read-data toggle; active low input, so inactive edge rises
  edge_flag u_rd_toggle (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .sig_i         (read_data_n_i),
    .toggle_mode_i (1'b1),
    .clear_i       (1'b0),
    .flag_o        (rd_toggle)
  );

  // write-data toggle on its inactive edge
  edge_flag u_wd_toggle (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .sig_i         (write_data_n_i),
    .toggle_mode_i (1'b1),
    .clear_i       (1'b0),
    .flag_o        (wd_toggle)
  );

  // write gate latch, cleared by input register read
  edge_flag u_wg_flag (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .sig_i         (write_gate_out_i),
    .toggle_mode_i (1'b0),
    .clear_i       (input_read),
    .flag_o        (wg_flag)
  );

  edge_flag u_rd_flag (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .sig_i         (read_data_n_i),
    .toggle_mode_i (1'b0),
    .clear_i       (input_read),
    .flag_o        (rd_flag)
  );

  // write-data latch, not qualified by write gate
  edge_flag u_wd_flag (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .sig_i         (write_data_n_i),
    .toggle_mode_i (1'b0),
    .clear_i       (input_read),
    .flag_o        (wd_flag)
  );

  // enhanced layout; latched layout
  // Motor bits read the pins, so they follow the swap as well
  assign drive_status_second = enhanced ?
    {`ENH_TOP_BITS,
     drive_output_control[`DOC_SEL_LO],
     wd_toggle,
     rd_toggle,
     write_gate_out_i,
     ~motor_out_one_n_o,
     ~motor_out_zero_n_o} :
    {second_drive_present_n_i,
     drive_select_out_one_n_o,
     drive_select_out_zero_n_o,
     wd_flag,
     rd_flag,
     wg_flag,
     drive_select_out_three_n_o,
     drive_select_out_two_n_o};

  // Read mux; unmapped offsets leave the bus floating
  always @* begin
    next_data = `BUS_IDLE;
    next_oe_n = `OE_OFF;
    if (rd_i) begin
      case (addr_i)
        `OFF_STATUS_SECOND: begin
          // baseline mode never drives this read
          if (enhanced || latched) begin
            next_data = drive_status_second;
            next_oe_n = `OE_ALL_ON;
          end
        end
        `OFF_OUTPUT_CONTROL: begin
          next_data = drive_output_control;
          next_oe_n = `OE_ALL_ON;
        end
        `OFF_TAPE_SCRATCH: begin
          // only the two low bits drive
          next_data = {6'h00, tape_select_scratch};
          next_oe_n = `OE_TAPE_ONLY;
        end
        default: begin
          next_data = `BUS_IDLE;
          next_oe_n = `OE_OFF;
        end
      endcase
    end
  end

  // Read data answers one clock after the strobe is taken
  // Holding rd_i for several clocks gives one answer per clock
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o      <= `BUS_IDLE;
      data_oe_n_o <= `OE_OFF;
    end else begin
      data_o      <= next_data;
      data_oe_n_o <= next_oe_n;
    end
  end

  // gate bit opens the pins; enhanced mode always open
  assign gate = enhanced || drive_output_control[`DOC_DMA_IRQ_GATE];

  // Hard reset floats the pins, since the mode is not known then;
  // in enhanced mode they open one clock after reset is released
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_req_o      <= 1'b0;
      dma_req_oe_n_o <= 1'b1;
      irq_o          <= 1'b0;
      irq_oe_n_o     <= 1'b1;
      dma_ack_n_o    <= 1'b1;
      tc_o           <= 1'b0;
    end else begin
      dma_req_o      <= gate && dma_req_i;
      dma_req_oe_n_o <= ~gate;
      irq_o          <= gate && irq_i;
      irq_oe_n_o     <= ~gate;
      dma_ack_n_o    <= gate ? dma_ack_n_i : 1'b1;
      tc_o           <= gate && tc_i;
    end
  end

endmodule

// ===== tb/fdc_regs_sva.sv
// Port checker for the drive control and status register bank.
// Assumes a bind to the top module and sees only its ports.
`timescale 1ns/1ps
`include "fdc_drive_regs_map.vh"

module fdc_regs_sva (
  input wire       clk_i,                      // Clock
  input wire       reset_n_i,                  // Hard reset
  input wire [2:0] addr_i,                     // Offset
  input wire       rd_i,                       // Read strobe
  input wire       wr_i,                       // Write strobe
  input wire [7:0] data_i,                     // Write data
  input wire [7:0] data_o,                     // Read data
  input wire [7:0] data_oe_n_o,                // Read enables
  input wire [1:0] mode_i,                     // Mode
  input wire       dma_req_oe_n_o,             // Request enable
  input wire       irq_oe_n_o,                 // Interrupt enable
  input wire       soft_reset_o,               // Soft reset level
  input wire       drive_select_out_zero_n_o,  // Select 0
  input wire       drive_select_out_one_n_o,   // Select 1
  input wire       drive_select_out_two_n_o,   // Select 2
  input wire       drive_select_out_three_n_o, // Select 3
  input wire       motor_out_zero_n_o,         // Motor 0
  input wire       motor_out_one_n_o           // Motor 1
);
  // Shared triggers; selects ordered as the latched layout wants them
  wire       st_rd = rd_i && addr_i == `OFF_STATUS_SECOND;
  wire       base = mode_i == `MODE_BASELINE;
  wire       enh = mode_i == `MODE_ENHANCED;
  wire       lat = mode_i == `MODE_LATCHED;
  wire       doc_wr = wr_i && addr_i == `OFF_OUTPUT_CONTROL;
  wire       srst_bit = data_i[`DOC_SOFT_RESET_N];
  wire [3:0] ds = {drive_select_out_one_n_o, drive_select_out_zero_n_o,
                   drive_select_out_three_n_o, drive_select_out_two_n_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_base_float; st_rd && base |=> data_oe_n_o == 8'hFF;
  endproperty
  a_base_float: assert property (p_base_float) else $error("bus driven");
  property p_enh_read;
    st_rd && enh |=> data_oe_n_o == 8'h00 && data_o[7:6] == 2'h3;
  endproperty
  a_enh_read: assert property (p_enh_read) else $error("bad top bits");
  property p_enh_motor; st_rd && enh |=> data_o[1:0] ==
    ~{$past(motor_out_one_n_o), $past(motor_out_zero_n_o)};
  endproperty
  a_enh_motor: assert property (p_enh_motor) else $error("motor bits");
  property p_lat_sel; st_rd && lat |=> {data_o[6:5], data_o[1:0]} == $past(ds);
  endproperty
  a_lat_sel: assert property (p_lat_sel) else $error("select bits");
  property p_one_sel; $onehot0(~ds);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects");
  property p_soft_rst; doc_wr |=> ##1 soft_reset_o == !$past(srst_bit, 2);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset");
  property p_enh_dma;
    $past(reset_n_i) && $past(enh) |-> !dma_req_oe_n_o && !irq_oe_n_o;
  endproperty
  a_enh_dma: assert property (p_enh_dma) else $error("pins floating");
  property p_tape_oe; rd_i && addr_i == `OFF_TAPE_SCRATCH |=>
    data_oe_n_o == 8'hFC && data_o[7:2] == 6'h00;
  endproperty
  a_tape_oe: assert property (p_tape_oe) else $error("tape enables");

  c_lat_read: cover property (st_rd && lat);
  c_doc_write: cover property (doc_wr);
  c_soft_pulse: cover property (soft_reset_o ##1 !soft_reset_o);
endmodule

bind floppy_drive_control_status_regs fdc_regs_sva fdc_regs_sva_i (
  .clk_i, .reset_n_i, .addr_i, .rd_i, .wr_i, .data_i, .data_o, .data_oe_n_o,
  .mode_i, .dma_req_oe_n_o, .irq_oe_n_o, .soft_reset_o,
  .drive_select_out_zero_n_o, .drive_select_out_one_n_o,
  .drive_select_out_two_n_o, .drive_select_out_three_n_o,
  .motor_out_zero_n_o, .motor_out_one_n_o);

// ===== tb/floppy_drive_model.sv
// Drive side model: turns one-cycle requests into data pulses.
// Assumes requests change on the falling edge of the clock.
`timescale 1ns/1ps

module floppy_drive_model (
  input  wire clk_i,          // Controller clock
  input  wire rd_go_i,        // Ask for one read-data pulse
  input  wire wd_go_i,        // Ask for one write-data pulse
  output reg  read_data_n_o,  // Read data, idles high
  output reg  write_data_n_o  // Write data, idles high
);
  // A full cycle low so no pulse slips between two samples
  always @(posedge clk_i) begin
    read_data_n_o <= ~rd_go_i;
    write_data_n_o <= ~wd_go_i;
  end
  initial begin
    read_data_n_o = 1'b1;
    write_data_n_o = 1'b1;
  end
endmodule

// ===== tb/floppy_drive_control_status_regs_tb.sv
// Self-checking bench for the drive control and status registers.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`include "fdc_drive_regs_map.vh"

module floppy_drive_control_status_regs_tb;
  reg        clk_i = 1'b0, reset_n_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
  reg        swap_drives_i = 1'b0, write_gate_out_i = 1'b0, rd_go = 1'b0;
  reg        second_drive_present_n_i = 1'b1, wd_go = 1'b0, tc_i = 1'b0;
  reg        dma_req_i = 1'b0, irq_i = 1'b0, dma_ack_n_i = 1'b1;
  reg  [2:0] addr_i = 3'h0;
  reg  [7:0] data_i = 8'h00, e;
  reg  [1:0] mode_i = 2'h1;
  wire       read_data_n_i, write_data_n_i, dma_req_o, dma_req_oe_n_o;
  wire       irq_o, irq_oe_n_o, dma_ack_n_o, tc_o, soft_reset_o;
  wire [7:0] data_o, data_oe_n_o;
  wire [3:0] sel_n, mot_n;
  integer    n_fail = 0, compares = 0, i, k;
  integer    doc = 0, tape = 0, rdt = 0, wdt = 0, rdf = 0, wdf = 0, wgf = 0;

  // 25 MHz controller clock
  always #20 clk_i = ~clk_i;

  floppy_drive_control_status_regs floppy_drive_control_status_regs_i (
    .clk_i, .reset_n_i, .addr_i, .rd_i, .wr_i, .data_i, .data_o,
    .data_oe_n_o, .mode_i, .swap_drives_i, .read_data_n_i, .write_data_n_i,
    .write_gate_out_i, .second_drive_present_n_i, .dma_req_i, .irq_i,
    .dma_ack_n_i, .tc_i, .dma_req_o, .dma_req_oe_n_o, .irq_o, .irq_oe_n_o,
    .dma_ack_n_o, .tc_o, .soft_reset_o,
    .drive_select_out_zero_n_o(sel_n[0]), .drive_select_out_one_n_o(sel_n[1]),
    .drive_select_out_two_n_o(sel_n[2]),
    .drive_select_out_three_n_o(sel_n[3]), .motor_out_zero_n_o(mot_n[0]),
    .motor_out_one_n_o(mot_n[1]), .motor_out_two_n_o(mot_n[2]),
    .motor_out_three_n_o(mot_n[3]));
  floppy_drive_model floppy_drive_model_i (.clk_i, .rd_go_i(rd_go),
    .wd_go_i(wd_go), .read_data_n_o(read_data_n_i),
    .write_data_n_o(write_data_n_i));

  task chk(input [63:0] nm, input [7:0] x, input [7:0] g);
    compares = compares + 1;
    if (g !== x) begin
      n_fail = n_fail + 1;
      $display("mismatch %0s exp %h got %h", nm, x, g);
    end
  endtask
  // Write is taken at one edge, pins follow at the next
  task wr(input [2:0] a, input [7:0] d);
    addr_i = a;
    data_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
    if (a == `OFF_OUTPUT_CONTROL) doc = d;
    if (a == `OFF_TAPE_SCRATCH) tape = d & 3;
    @(negedge clk_i);
  endtask
  // Read answer stands in the cycle after the read edge; a gap
  // cycle keeps rd_i from being lowered and raised in one step
  task rchk(input [2:0] a, input [63:0] nm, input [7:0] x, input [7:0] xoe);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk("oe", xoe, data_oe_n_o);
    if (xoe != 8'hFF) chk(nm, x, data_o);
    if (a == `OFF_DIGITAL_INPUT) {rdf, wdf, wgf} = 0;
    @(negedge clk_i);
  endtask
  // One drive pulse; its trailing rising edge counts
  task pulse(input w);
    rd_go = !w;
    wd_go = w;
    @(negedge clk_i);
    rd_go = 1'b0;
    wd_go = 1'b0;
    repeat (3) @(negedge clk_i);
    wdt = wdt + w;
    wdf = wdf | w;
    rdt = rdt + !w;
    rdf = rdf | !w;
  endtask
  // Expected {selects, motors}, active low
  function [7:0] dec(input integer d, input s);
    reg [3:0] sl, m;
    reg [1:0] c;
    c = d[1:0];
    sl = 4'hF;
    if (d[4 + c]) sl[(s && c < 2) ? 1 - c : c] = 1'b0;
    m = ~d[7:4];
    if (s) m[1:0] = {m[0], m[1]};
    dec = {sl, m};
  endfunction
  function [7:0] stat(input integer d);
    reg [7:0] p;
    p = dec(d, swap_drives_i);
    if (mode_i == `MODE_ENHANCED)
      stat = {2'h3, d[0], wdt[0], rdt[0], write_gate_out_i, ~p[1], ~p[0]};
    else
      stat = {second_drive_present_n_i, p[5:4], wdf[0], rdf[0], wgf[0], p[7:6]};
  endfunction
  task results;
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    k = $urandom(10);
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    // Hard reset state of pins and registers
    chk("pins", 8'hFF, {sel_n, mot_n});
    rchk(`OFF_OUTPUT_CONTROL, "doc", 8'h00, 8'h00);
    rchk(`OFF_TAPE_SCRATCH, "tape", 8'h00, 8'hFC);
    rchk(`OFF_STATUS_SECOND, "status", 8'hC0, 8'h00);
    // Modes 0 to 2 and decodes, tabled values first, then random ones
    for (i = 0; i < 24; i = i + 1) begin
      mode_i = i % 3;
      swap_drives_i = i[2];
      second_drive_present_n_i = $urandom % 2;
      k = (i < 4) ? (i[0] ? 8'h2D : 8'h1C) : $urandom % 256;
      wr(`OFF_OUTPUT_CONTROL, k[7:0]);
      chk("pins", dec(doc, swap_drives_i), {sel_n, mot_n});
      chk("srst", {7'h0, !doc[2]}, {7'h0, soft_reset_o});
      rchk(`OFF_OUTPUT_CONTROL, "doc", doc[7:0], 8'h00);
      e = mode_i == 2'h0 ? 8'hFF : 8'h00;
      rchk(`OFF_STATUS_SECOND, "status", stat(doc), e);
    end
    // Toggles and latched flags, then the clearing input read
    for (i = 1; i < 3; i = i + 1) begin
      mode_i = i;
      wgf = 1;
      write_gate_out_i = 1'b1;
      for (k = $urandom % 3; k >= 0; k = k - 1) pulse(1'b0);
      pulse(1'b1);
      rchk(`OFF_STATUS_SECOND, "status", stat(doc), 8'h00);
      write_gate_out_i = 1'b0;
      rchk(`OFF_DIGITAL_INPUT, "din", 8'h00, 8'hFF);
      rchk(`OFF_STATUS_SECOND, "status", stat(doc), 8'h00);
    end
    // Soft reset by two writes leaves the other bits and the tape
    mode_i = 2'h1;
    wr(`OFF_TAPE_SCRATCH, $urandom % 256);
    k = $urandom % 256;
    wr(`OFF_OUTPUT_CONTROL, k[7:0] & 8'hFB);
    chk("srst", 8'h01, {7'h0, soft_reset_o});
    wr(`OFF_OUTPUT_CONTROL, k[7:0] | 8'h04);
    rchk(`OFF_OUTPUT_CONTROL, "doc", doc[7:0], 8'h00);
    rchk(`OFF_TAPE_SCRATCH, "tape", tape[7:0], 8'hFC);
    rchk(`OFF_STATUS_SECOND, "status", stat(doc), 8'h00);
    // DMA and interrupt gating by mode and the gate bit
    for (i = 0; i < 12; i = i + 1) begin
      mode_i = i < 8 ? 2'h0 : 2'h1;
      if (i % 4 == 0) wr(`OFF_OUTPUT_CONTROL, {4'h0, i[2], 3'h4});
      {dma_req_i, irq_i, dma_ack_n_i, tc_i} = $urandom % 16;
      @(negedge clk_i);
      k = mode_i == 2'h1 || doc[3];
      e = k ? {4'h0, dma_req_i, irq_i, dma_ack_n_i, tc_i} : 8'h02;
      chk("dma", e, {4'h0, dma_req_o, irq_o, dma_ack_n_o, tc_o});
      e = k ? 8'h00 : 8'h03;
      chk("dma_oe", e, {6'h0, dma_req_oe_n_o, irq_oe_n_o});
    end
    rchk(3'h6, "unmap", 8'h00, 8'hFF);
    results;
  end

  // Cut a hang short; the run needs far fewer cycles than this
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail = n_fail + 1;
    results;
  end
endmodule
